// ### logic/bsfu_pkg.sv
package bsfu_pkg;

  localparam int DATA_W = 8;
  localparam int IDX_W = 3;
  localparam int ADDR_W = 12;
  localparam int BUS_W = 32;

  // Byte addresses of the register words.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_OPERAND = 12'h004;
  localparam logic [11:0] OFS_RESULT = 12'h008;
  localparam logic [11:0] OFS_FLAGS = 12'h00c;
  localparam logic [11:0] OFS_IO_BASE = 12'h020;

  // Fields of the command word.
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 5;
  localparam int CTRL_IDX_LSB = 8;
  localparam int CTRL_IO_LSB = 12;

  // Positions of the status flags.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Values after reset.
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] OPERAND_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] IO_RST = 8'h00;
  localparam logic [4:0] CMD_OP_RST = 5'h00;

  typedef enum logic [4:0] {
    OP_NONE = 5'b00000,
    OP_IO_BIT_SET = 5'b00001,
    OP_IO_BIT_CLEAR = 5'b00010,
    OP_LOGICAL_LEFT_SHIFT = 5'b00011,
    OP_LOGICAL_RIGHT_SHIFT = 5'b00100,
    OP_ROTATE_LEFT_CARRY = 5'b00101,
    OP_ROTATE_RIGHT_CARRY = 5'b00110,
    OP_ARITH_RIGHT_SHIFT = 5'b00111,
    OP_NIBBLE_SWAP = 5'b01000,
    OP_STATUS_BIT_SET = 5'b01001,
    OP_STATUS_BIT_CLEAR = 5'b01010,
    OP_BIT_TO_TRANSFER_FLAG = 5'b01011,
    OP_TRANSFER_FLAG_TO_BIT = 5'b01100,
    OP_CARRY_SET = 5'b01101,
    OP_CARRY_CLEAR = 5'b01110,
    OP_NEGATIVE_SET = 5'b01111,
    OP_NEGATIVE_CLEAR = 5'b10000,
    OP_ZERO_SET = 5'b10001,
    OP_ZERO_CLEAR = 5'b10010,
    OP_IRQ_GLOBAL_ON = 5'b10011,
    OP_IRQ_GLOBAL_OFF = 5'b10100
  } bsfu_op_e;

  typedef struct packed {
    bsfu_op_e op;
    logic [2:0] idx;
    logic [2:0] io_sel;
  } bsfu_cmd_s;

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] flags;
    logic [7:0] io_value;
    logic wr_rd;
    logic wr_io;
    logic legal;
  } bsfu_res_s;

endpackage

// ### logic/bsfu_alu.sv
module bsfu_alu (
  input wire bsfu_pkg::bsfu_cmd_s cmd, // Decoded command.
  input wire logic [7:0] operand, // Destination or source register value.
  input wire logic [7:0] flags, // Current status flags.
  input wire logic [7:0] io_value, // Current value of the addressed I/O register.
  output bsfu_pkg::bsfu_res_s res // Next values and write enables.
);

  logic shift_op;
  logic carry_out;

  always_comb begin
    res = '0;
    res.value = operand;
    res.flags = flags;
    res.io_value = io_value;
    res.legal = 1'b1;
    shift_op = 1'b0;
    carry_out = 1'b0;
    case (cmd.op)
      bsfu_pkg::OP_NONE: begin
        res.legal = 1'b1;
      end
      bsfu_pkg::OP_IO_BIT_SET: begin
        res.io_value[cmd.idx] = 1'b1;
        res.wr_io = 1'b1;
      end
      bsfu_pkg::OP_IO_BIT_CLEAR: begin
        res.io_value[cmd.idx] = 1'b0;
        res.wr_io = 1'b1;
      end
      bsfu_pkg::OP_LOGICAL_LEFT_SHIFT: begin
        res.value = {operand[6:0], 1'b0};
        carry_out = operand[7];
        shift_op = 1'b1;
      end
      bsfu_pkg::OP_LOGICAL_RIGHT_SHIFT: begin
        res.value = {1'b0, operand[7:1]};
        carry_out = operand[0];
        shift_op = 1'b1;
      end
      bsfu_pkg::OP_ROTATE_LEFT_CARRY: begin
        res.value = {operand[6:0], flags[bsfu_pkg::FLAG_C]};
        carry_out = operand[7];
        shift_op = 1'b1;
      end
      bsfu_pkg::OP_ROTATE_RIGHT_CARRY: begin
        res.value = {flags[bsfu_pkg::FLAG_C], operand[7:1]};
        carry_out = operand[0];
        shift_op = 1'b1;
      end
      bsfu_pkg::OP_ARITH_RIGHT_SHIFT: begin
        res.value = {operand[7], operand[7:1]};
        carry_out = operand[0];
        shift_op = 1'b1;
      end
      bsfu_pkg::OP_NIBBLE_SWAP: begin
        res.value = {operand[3:0], operand[7:4]};
      end
      bsfu_pkg::OP_STATUS_BIT_SET: res.flags[cmd.idx] = 1'b1;
      bsfu_pkg::OP_STATUS_BIT_CLEAR: res.flags[cmd.idx] = 1'b0;
      bsfu_pkg::OP_BIT_TO_TRANSFER_FLAG: res.flags[bsfu_pkg::FLAG_T] = operand[cmd.idx];
      bsfu_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
        res.value[cmd.idx] = flags[bsfu_pkg::FLAG_T];
      end
      bsfu_pkg::OP_CARRY_SET: res.flags[bsfu_pkg::FLAG_C] = 1'b1;
      bsfu_pkg::OP_CARRY_CLEAR: res.flags[bsfu_pkg::FLAG_C] = 1'b0;
      bsfu_pkg::OP_NEGATIVE_SET: res.flags[bsfu_pkg::FLAG_N] = 1'b1;
      bsfu_pkg::OP_NEGATIVE_CLEAR: res.flags[bsfu_pkg::FLAG_N] = 1'b0;
      bsfu_pkg::OP_ZERO_SET: res.flags[bsfu_pkg::FLAG_Z] = 1'b1;
      bsfu_pkg::OP_ZERO_CLEAR: res.flags[bsfu_pkg::FLAG_Z] = 1'b0;
      bsfu_pkg::OP_IRQ_GLOBAL_ON: res.flags[bsfu_pkg::FLAG_I] = 1'b1;
      bsfu_pkg::OP_IRQ_GLOBAL_OFF: res.flags[bsfu_pkg::FLAG_I] = 1'b0;
      default: res.legal = 1'b0;
    endcase
    // Every shift and rotate writes the register and updates Z, C, N and V.
    if (shift_op) begin
      res.flags[bsfu_pkg::FLAG_C] = carry_out;
      res.flags[bsfu_pkg::FLAG_N] = res.value[7];
      res.flags[bsfu_pkg::FLAG_Z] = (res.value == 8'h00);
      res.flags[bsfu_pkg::FLAG_V] = res.value[7] ^ carry_out;
    end
    res.wr_rd = shift_op || (cmd.op == bsfu_pkg::OP_NIBBLE_SWAP) ||
                (cmd.op == bsfu_pkg::OP_TRANSFER_FLAG_TO_BIT);
  end

endmodule

// ### logic/bsfu_top.sv
// What this block does
// - Setting or clearing an I/O bit changes only bit b of that register.
// - Logical left shift moves bits up and loads zero into bit 0.
// - Logical right shift moves bits down and loads zero into bit 7.
// - Rotate left loads old carry into bit 0, old bit 7 into carry.
// - Rotate right loads old carry into bit 7, old bit 0 into carry.
// - Arithmetic right shift moves bits down and keeps the sign bit.
// - Nibble swap exchanges the low and high four bits at once.
// - Generic flag set writes one, flag clear writes zero, at index s.
// - Bit store copies source bit b into the transfer flag.
// - Bit load copies the transfer flag into destination bit b only.
// - Carry set and clear touch only the carry flag.
// - Negative set and clear touch only the negative flag.
// - Zero set and clear touch only the zero flag.
// - Global interrupt on sets, off clears the interrupt flag.
module bsfu_top #(
  parameter int NUM_IO = 8
) (
  input wire logic clk, // Core clock, 50 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [bsfu_pkg::ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [bsfu_pkg::BUS_W-1:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [bsfu_pkg::BUS_W-1:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  output logic [NUM_IO*8-1:0] io_regs, // All I/O registers, register k at bits 8k+7..8k.
  output logic [7:0] status_flags, // Status flags.
  output logic irq_global_en // Global interrupt enable flag.
);

  typedef enum logic [1:0] {
    SLV_IDLE = 2'b00,
    SLV_WAIT = 2'b01,
    SLV_DONE = 2'b10
  } bsfu_slv_e;

  bsfu_slv_e slv_q;
  bsfu_slv_e slv_d;

  logic [7:0] operand_q;
  logic [7:0] result_q;
  logic [7:0] flags_q;
  logic [7:0] io_q [NUM_IO];

  logic [bsfu_pkg::BUS_W-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  bsfu_pkg::bsfu_cmd_s cmd;
  bsfu_pkg::bsfu_res_s res;
  logic [7:0] io_cur;

  logic hit_ctrl;
  logic hit_operand;
  logic hit_result;
  logic hit_flags;
  logic hit_io;
  logic [2:0] io_addr_idx;
  logic io_addr_ok;
  logic [bsfu_pkg::ADDR_W-1:0] io_ofs;
  logic access;
  logic commit;
  logic wr_low;
  logic bad_access;
  logic [7:0] rd_byte;
  logic cmd_io_ok;
  logic cmd_ok;

  // Command fields come straight from the write data of a command write.
  assign cmd.op = bsfu_pkg::bsfu_op_e'(pwdata[bsfu_pkg::CTRL_OP_LSB +: bsfu_pkg::CTRL_OP_W]);
  assign cmd.idx = pwdata[bsfu_pkg::CTRL_IDX_LSB +: bsfu_pkg::IDX_W];
  assign cmd.io_sel = pwdata[bsfu_pkg::CTRL_IO_LSB +: bsfu_pkg::IDX_W];

  assign cmd_io_ok = (32'(cmd.io_sel) < NUM_IO);
  assign io_cur = cmd_io_ok ? io_q[cmd.io_sel] : 8'h00;

  bsfu_alu u_alu (
    .cmd(cmd),
    .operand(operand_q),
    .flags(flags_q),
    .io_value(io_cur),
    .res(res)
  );

  // An I/O-bit command that names an absent I/O register is refused.
  assign cmd_ok = res.legal && (cmd_io_ok || !res.wr_io);

  assign io_ofs = paddr - bsfu_pkg::OFS_IO_BASE;
  assign io_addr_idx = io_ofs[4:2];

  always_comb begin
    hit_ctrl = 1'b0;
    hit_operand = 1'b0;
    hit_result = 1'b0;
    hit_flags = 1'b0;
    hit_io = 1'b0;
    io_addr_ok = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      hit_ctrl = 1'b0;
    end else if (paddr == bsfu_pkg::OFS_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (paddr == bsfu_pkg::OFS_OPERAND) begin
      hit_operand = 1'b1;
    end else if (paddr == bsfu_pkg::OFS_RESULT) begin
      hit_result = 1'b1;
    end else if (paddr == bsfu_pkg::OFS_FLAGS) begin
      hit_flags = 1'b1;
    end else if (paddr >= bsfu_pkg::OFS_IO_BASE &&
                 32'(io_ofs[bsfu_pkg::ADDR_W-1:2]) < NUM_IO) begin
      hit_io = 1'b1;
      io_addr_ok = 1'b1;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (hit_operand) begin
      rd_byte = operand_q;
    end else if (hit_result) begin
      rd_byte = result_q;
    end else if (hit_flags) begin
      rd_byte = flags_q;
    end else if (hit_io && io_addr_ok) begin
      rd_byte = io_q[io_addr_idx];
    end
  end

  // Unmapped addresses, writes to the result and bad commands answer with an error.
  always_comb begin
    bad_access = 1'b0;
    if (!(hit_ctrl || hit_operand || hit_result || hit_flags || hit_io)) begin
      bad_access = 1'b1;
    end else if (pwrite && hit_result) begin
      bad_access = 1'b1;
    end else if (pwrite && hit_ctrl && pstrb[0] && !cmd_ok) begin
      bad_access = 1'b1;
    end
  end

  // Each transfer takes one wait state: ready rises in the second access cycle.
  always_comb begin
    slv_d = slv_q;
    case (slv_q)
      SLV_IDLE: begin
        if (psel && penable) begin
          slv_d = SLV_WAIT;
        end
      end
      SLV_WAIT: slv_d = SLV_DONE;
      SLV_DONE: slv_d = SLV_IDLE;
      default: slv_d = SLV_IDLE;
    endcase
  end

  assign access = psel && penable && (slv_q == SLV_IDLE);
  assign commit = psel && penable && pready_q;
  assign wr_low = commit && pwrite && pstrb[0] && !pslverr_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      slv_q <= SLV_IDLE;
    end else if (slv_q == SLV_WAIT && !(psel && penable)) begin
      slv_q <= SLV_IDLE;
    end else begin
      slv_q <= slv_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (access) begin
      pready_q <= 1'b1;
      pslverr_q <= bad_access;
      prdata_q <= (pwrite || bad_access) ? '0 : {24'h000000, rd_byte};
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      operand_q <= bsfu_pkg::OPERAND_RST;
    end else if (wr_low && hit_operand) begin
      operand_q <= pwdata[7:0];
    end
  end

  // The result holds the register value after the last command that wrote it.
  always_ff @(posedge clk) begin
    if (srst) begin
      result_q <= bsfu_pkg::RESULT_RST;
    end else if (wr_low && hit_ctrl && res.wr_rd) begin
      result_q <= res.value;
    end
  end

  // Flags change only through a command or a direct write of the flag word.
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_q <= bsfu_pkg::FLAGS_RST;
    end else if (wr_low && hit_ctrl) begin
      flags_q <= res.flags;
    end else if (wr_low && hit_flags) begin
      flags_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int k = 0; k < NUM_IO; k++) begin
        io_q[k] <= bsfu_pkg::IO_RST;
      end
    end else if (wr_low && hit_ctrl && res.wr_io) begin
      io_q[cmd.io_sel] <= res.io_value;
    end else if (wr_low && hit_io) begin
      io_q[io_addr_idx] <= pwdata[7:0];
    end
  end

  always_comb begin
    for (int k = 0; k < NUM_IO; k++) begin
      io_regs[k*8 +: 8] = io_q[k];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign status_flags = flags_q;
  assign irq_global_en = flags_q[bsfu_pkg::FLAG_I];

endmodule

// ### sim/bsfu_assertions.sv
module bsfu_assertions #(
  parameter int NUM_IO = 8
) (
  input wire logic clk, // Clock.
  input wire logic srst, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Write.
  input wire logic [bsfu_pkg::ADDR_W-1:0] paddr, // Address.
  input wire logic [bsfu_pkg::BUS_W-1:0] pwdata, // Write data.
  input wire logic [3:0] pstrb, // Strobes.
  input wire logic [bsfu_pkg::BUS_W-1:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic [NUM_IO*8-1:0] io_regs, // I/O registers.
  input wire logic [7:0] status_flags, // Flags.
  input wire logic irq_global_en // Interrupt enable.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire logic [4:0] op = pwdata[4:0];
  wire logic [2:0] bi = pwdata[10:8];
  wire logic [5:0] pos = {pwdata[14:12], pwdata[10:8]};
  wire logic [NUM_IO*8-1:0] one = {{(NUM_IO*8-1){1'b0}}, 1'b1};
  wire logic cmd = psel && penable && pready && pwrite && !pslverr && pstrb[0]
    && paddr == bsfu_pkg::OFS_CTRL;
  property p_io_set;
    cmd && op == 5'h01 |=> io_regs == ($past(io_regs) | (one << $past(pos)));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong");
  property p_io_clr;
    cmd && op == 5'h02 |=> io_regs == ($past(io_regs) & ~(one << $past(pos)));
  endproperty
  a_io_clr: assert property (p_io_clr) else $error("io bit clear wrong");
  property p_st_set;
    cmd && op == 5'h09 |=> status_flags == ($past(status_flags) | (8'h01 << $past(bi)));
  endproperty
  a_st_set: assert property (p_st_set) else $error("status bit set wrong");
  property p_c_set;
    cmd && op == 5'h0d |=> status_flags == ($past(status_flags) | 8'h01);
  endproperty
  a_c_set: assert property (p_c_set) else $error("carry set wrong");
  property p_c_clr;
    cmd && op == 5'h0e |=> status_flags == ($past(status_flags) & 8'hfe);
  endproperty
  a_c_clr: assert property (p_c_clr) else $error("carry clear wrong");
  property p_n_set;
    cmd && op == 5'h0f |=> status_flags == ($past(status_flags) | 8'h04);
  endproperty
  a_n_set: assert property (p_n_set) else $error("negative set wrong");
  property p_z_clr;
    cmd && op == 5'h12 |=> status_flags == ($past(status_flags) & 8'hfd);
  endproperty
  a_z_clr: assert property (p_z_clr) else $error("zero clear wrong");
  property p_i_on;
    cmd && op == 5'h13 |=> irq_global_en && status_flags[7] && $stable(io_regs);
  endproperty
  a_i_on: assert property (p_i_on) else $error("irq enable wrong");
  property p_i_off;
    cmd && op == 5'h14 |=> !irq_global_en ##1 !irq_global_en || cmd;
  endproperty
  a_i_off: assert property (p_i_off) else $error("irq disable wrong");
endmodule

bind bsfu_top bsfu_assertions #(.NUM_IO(NUM_IO)) u_chk (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_regs(io_regs),
  .status_flags(status_flags), .irq_global_en(irq_global_en));

// ### sim/bsfu_top_tb.sv
module bsfu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NIO = 6;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, e, irq_global_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [NIO*8-1:0] io_regs;
  logic [7:0] status_flags, o, f, r, iv;
  logic [4:0] op;
  logic [2:0] b, k;
  logic [15:0] x;
  int errors, num_checks, seed;
  bsfu_top #(.NUM_IO(NIO)) dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_regs(io_regs), .status_flags(status_flags),
    .irq_global_en(irq_global_en));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task finish_test;
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] w);
    num_checks++;
    if (g !== w) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, w);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        finish_test;
      end
      @(posedge clk);
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Returns the expected result and flags of one command.
  function automatic logic [15:0] exp_op(logic [4:0] c, logic [2:0] i, logic [7:0] v, fl, rs);
    logic [7:0] nr, nf;
    logic cy;
    nr = rs;
    nf = fl;
    cy = fl[0];
    case (c)
      3: begin nr = {v[6:0], 1'b0}; cy = v[7]; end
      4: begin nr = {1'b0, v[7:1]}; cy = v[0]; end
      5: begin nr = {v[6:0], fl[0]}; cy = v[7]; end
      6: begin nr = {fl[0], v[7:1]}; cy = v[0]; end
      7: begin nr = {v[7], v[7:1]}; cy = v[0]; end
      8: nr = {v[3:0], v[7:4]};
      9: nf[i] = 1'b1;
      10: nf[i] = 1'b0;
      11: nf[6] = v[i];
      12: begin nr = v; nr[i] = fl[6]; end
      13, 14: nf[0] = c[0];
      15, 16: nf[2] = c[0];
      17, 18: nf[1] = c[0];
      19, 20: nf[7] = c[0];
      default: nr = rs;
    endcase
    if (c >= 3 && c <= 7) nf[3:0] = {nr[7] ^ cy, nr[7], nr == 8'h00, cy};
    return {nr, nf};
  endfunction
  initial begin
    #200000;
    errors++;
    finish_test;
  end
  initial begin
    seed = 32'h20cf;
    {errors, num_checks} = 0;
    {srst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 44'h0, 4'hf};
    r = bsfu_pkg::RESULT_RST;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 80; i++) begin
      o = 8'($random(seed));
      f = 8'($random(seed));
      iv = 8'($random(seed));
      b = 3'($random(seed));
      k = 3'($unsigned($random(seed)) % NIO);
      op = (i < 21) ? 5'(i) : 5'($unsigned($random(seed)) % 21);
      apb(1'b1, bsfu_pkg::OFS_OPERAND, {24'h0, o});
      apb(1'b1, bsfu_pkg::OFS_FLAGS, {24'h0, f});
      apb(1'b1, 12'(bsfu_pkg::OFS_IO_BASE + 4 * k), {24'h0, iv});
      apb(1'b1, bsfu_pkg::OFS_CTRL, {17'h0, k, 1'b0, b, 3'h0, op});
      chk(32'(e), 32'h0);
      x = exp_op(op, b, o, f, r);
      r = x[15:8];
      f = x[7:0];
      if (op == 5'h01) iv[b] = 1'b1;
      if (op == 5'h02) iv[b] = 1'b0;
      apb(1'b0, bsfu_pkg::OFS_RESULT, 32'h0);
      chk(rd, {24'h0, r});
      apb(1'b0, bsfu_pkg::OFS_FLAGS, 32'h0);
      chk(rd, {24'h0, f});
      chk(32'(io_regs[8*k +: 8]), 32'(iv));
      chk(32'(irq_global_en), 32'(f[7]));
      chk(32'(status_flags), 32'(f));
    end
    apb(1'b1, bsfu_pkg::OFS_CTRL, 32'h15);
    chk(32'(e), 32'h1);
    apb(1'b1, bsfu_pkg::OFS_CTRL, {17'h0, 3'h7, 1'b0, 3'h2, 8'h01});
    chk(32'(e), 32'h1);
    apb(1'b0, bsfu_pkg::OFS_FLAGS, 32'h0);
    chk(rd, {24'h0, f});
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], e}, 32'h1);
    apb(1'b1, bsfu_pkg::OFS_RESULT, 32'hff);
    chk(32'(e), 32'h1);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, bsfu_pkg::OFS_RESULT, 32'h0);
    chk(rd, 32'(bsfu_pkg::RESULT_RST));
    chk(32'(|io_regs), 32'h0);
    chk(32'(status_flags), 32'(bsfu_pkg::FLAGS_RST));
    finish_test;
  end
endmodule
